// ===== hdl/fis_pkg.sv
// constants, offsets and field positions of the forwarding and interrupt status block
// ----------------------------------------------------------------------------
// Operation
// - round-robin mode serves ready sources in rotating turn, without alignment.
// - round-robin enable resets to one; software writes zero or one.
// - reading forwarding status clears the failure flag.
// - synchronized bit shows aligned delivery now; zero when aligned mode off.
// - global enable bit 7 gates the irq_n interrupt output; blk_irq is not gated.
// - separate enables at bits 4, 1, 0; all reset to zero.
// - summary bit 7 set when any enabled source is pending, ignoring global enable.
// - transmitter pending bit is read-only, cleared by reading transmitter event register.
// - aligned mode decode: 00 off, 01 basic, 10 interleave, 11 concatenate.
// ----------------------------------------------------------------------------
package fis_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] FIS_IDX_FWD_CTL = 8'h21;
  localparam logic [7:0] FIS_IDX_FORWARDING_SYNC_STATUS = 8'h22;
  localparam logic [7:0] FIS_IDX_IRQ_CTL = 8'h23;
  localparam logic [7:0] FIS_IDX_IRQ_STS = 8'h24;
  localparam logic [7:0] FIS_IDX_TX_EVT = 8'h30;
  localparam logic [7:0] FIS_IDX_RX_EVT_A = 8'h31;
  localparam logic [7:0] FIS_IDX_RX_EVT_B = 8'h32;
  localparam logic [7:0] FIS_IDX_RX_PKT_EVT = 8'h33;
  localparam logic [7:0] FIS_IDX_EVT_MASK = 8'h34;
  localparam logic [7:0] FIS_IDX_EVT_STAT = 8'h35;
  // field positions
  localparam int FIS_RR_BIT = 0;
  localparam int FIS_MODE_LO = 2;
  localparam int FIS_SYNC_BIT = 0;
  localparam int FIS_FAIL_BIT = 2;
  localparam int FIS_GIE_BIT = 7;
  localparam int FIS_TX_BIT = 4;
  localparam int FIS_RX1_BIT = 1;
  localparam int FIS_RX0_BIT = 0;
  localparam int FIS_SUM_BIT = 7;
  // reset values
  localparam logic FIS_RR_RESET = 1'h1;
  localparam logic [1:0] FIS_MODE_RESET = 2'h0;
  localparam logic [7:0] FIS_IRQ_CTL_RESET = 8'h00;
  localparam logic [7:0] FIS_IRQ_CTL_MASK = 8'h93;
  // aligned forwarding modes
  typedef enum logic [1:0] {
    FIS_MODE_OFF = 2'h0,
    FIS_MODE_BASIC = 2'h1,
    FIS_MODE_INTERLEAVE = 2'h2,
    FIS_MODE_CONCAT = 2'h3
  } fis_mode_e;
  // block event bits in the local event status and mask registers
  localparam int FIS_EV_FAIL = 0;
  localparam int FIS_EV_LOCK = 1;
  localparam int FIS_EV_W = 2;
  // bus transfer codes
  localparam logic [1:0] FIS_HTRANS_NONSEQ = 2'h2;
endpackage : fis_pkg

// ===== hdl/fis_arbiter.sv
// two-port rotating forwarding arbiter with alignment tracking
`timescale 1ns/1ns
`default_nettype none
module fis_arbiter
  import fis_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // configuration
  input wire logic rr_en,
  input wire logic [1:0] mode,
  // source readiness and frame progress
  input wire logic [1:0] src_ready,
  input wire logic [1:0] src_enabled,
  input wire logic frame_done,
  input wire logic align_lost,
  // results
  output logic [1:0] grant,
  output logic aligned,
  output logic fail_pulse
);
  logic last_reg;
  logic frame_ok_reg;
  logic aligned_reg;
  logic fail_reg;
  logic [1:0] grant_reg;
  logic sync_on;
  logic all_ready;

  assign sync_on = (mode != FIS_MODE_OFF);
  assign all_ready = ((src_ready & src_enabled) == src_enabled) && (src_enabled != 2'h0);

  // rotating grant: the port served last yields when both wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant_reg <= 2'h0;
      last_reg <= 1'b1;
    end else begin
      grant_reg <= 2'h0;
      if (rr_en && !sync_on) begin
        if (src_ready == 2'h3) begin
          grant_reg <= last_reg ? 2'h1 : 2'h2;
          last_reg <= ~last_reg;
        end else if (src_ready[0]) begin
          grant_reg <= 2'h1;
          last_reg <= 1'b0;
        end else if (src_ready[1]) begin
          grant_reg <= 2'h2;
          last_reg <= 1'b1;
        end
      end else if (sync_on && all_ready) begin
        grant_reg <= src_enabled; // aligned: all enabled ports together
      end
    end
  end

  // alignment tracking; a failure only counts after one good frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_ok_reg <= 1'b0;
      aligned_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      fail_reg <= 1'b0;
      aligned_reg <= sync_on && all_ready && !align_lost;
      if (!sync_on) begin
        frame_ok_reg <= 1'b0;
      end else if (align_lost) begin
        fail_reg <= frame_ok_reg;
        frame_ok_reg <= 1'b0;
      end else if (frame_done) begin
        frame_ok_reg <= 1'b1;
      end
    end
  end

  assign grant = grant_reg;
  assign aligned = aligned_reg;
  assign fail_pulse = fail_reg;

  a_fail_after_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    fail_pulse |-> $past(frame_ok_reg) && $past(align_lost))
    else $error("failure flagged without a prior good frame");
  a_sync_off_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(mode) == FIS_MODE_OFF |-> !aligned)
    else $error("aligned shown while aligned mode off");
  a_rr_rotate: assert property (@(posedge hclk) disable iff (!hresetn)
    rr_en && mode == FIS_MODE_OFF && src_ready == 2'h3 ##1 grant == 2'h1 && rr_en && mode == FIS_MODE_OFF
    && src_ready == 2'h3 |=> grant == 2'h2)
    else $error("round-robin grant did not rotate");
endmodule : fis_arbiter
`default_nettype wire

// ===== hdl/fis_top.sv
// forwarding status and interrupt aggregation with an ahb-lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fis_top
  import fis_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pending events from the port logic, one-cycle pulses on hclk
  input wire logic tx_event,
  input wire logic rx0_event,
  input wire logic rx1_event,
  // forwarding engine status from the data path
  input wire logic [1:0] src_ready,
  input wire logic [1:0] src_enabled,
  input wire logic frame_done,
  input wire logic align_lost,
  // outputs
  output logic [1:0] fwd_grant,
  output logic irq_n,
  output logic blk_irq
);
  // ----------------------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic rd_valid;
  logic [7:0] rd_idx;
  logic [31:0] rdata_next;
  logic [31:0] hrdata_reg;

  // register index from a byte address; unaligned or high bits miss all registers
  function automatic logic [7:0] fis_index(input logic [31:0] a);
    fis_index = (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? a[9:2] : 8'hff;
  endfunction : fis_index

  assign rd_valid = hsel && hready && htrans == FIS_HTRANS_NONSEQ && !hwrite;
  assign rd_idx = fis_index(haddr);

  // writes land in the data phase, one cycle after the address is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else begin
      wr_pend_reg <= hsel && hready && htrans == FIS_HTRANS_NONSEQ && hwrite;
      wr_idx_reg <= fis_index(haddr);
    end
  end

  // ----------------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------------
  logic rr_en_reg;
  logic [1:0] mode_reg;
  logic [7:0] irq_ctl_reg;
  logic [FIS_EV_W-1:0] ev_mask_reg;

  // configuration writes take the data word that follows the captured address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rr_en_reg <= FIS_RR_RESET;
      mode_reg <= FIS_MODE_RESET;
      irq_ctl_reg <= FIS_IRQ_CTL_RESET;
      ev_mask_reg <= '0;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        FIS_IDX_FWD_CTL: begin
          rr_en_reg <= hwdata[FIS_RR_BIT];
          mode_reg <= hwdata[FIS_MODE_LO+1:FIS_MODE_LO];
        end
        FIS_IDX_IRQ_CTL: irq_ctl_reg <= hwdata[7:0] & FIS_IRQ_CTL_MASK;
        FIS_IDX_EVT_MASK: ev_mask_reg <= hwdata[FIS_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // forwarding engine
  // ----------------------------------------------------------------------------
  logic aligned;
  logic fail_pulse;
  logic [1:0] grant;

  // the two schemes are exclusive by software convention; aligned mode wins if both are set
  fis_arbiter u_arb (
    .hclk(hclk),
    .hresetn(hresetn),
    .rr_en(rr_en_reg),
    .mode(mode_reg),
    .src_ready(src_ready),
    .src_enabled(src_enabled),
    .frame_done(frame_done),
    .align_lost(align_lost),
    .grant(grant),
    .aligned(aligned),
    .fail_pulse(fail_pulse)
  );

  // ----------------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------------
  logic fail_reg;
  logic tx_pend_reg;
  logic rx0_pend_reg;
  logic rx1_pend_reg;
  logic rd_forwarding_sync_status;
  logic rd_rx_evt;

  assign rd_forwarding_sync_status = rd_valid && rd_idx == FIS_IDX_FORWARDING_SYNC_STATUS;
  assign rd_rx_evt = rd_valid && (rd_idx == FIS_IDX_RX_EVT_A || rd_idx == FIS_IDX_RX_EVT_B
                     || rd_idx == FIS_IDX_RX_PKT_EVT);

  // sticky flags: a new event in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_reg <= 1'b0;
    end else if (fail_pulse) begin
      fail_reg <= 1'b1;
    end else if (rd_forwarding_sync_status) begin
      fail_reg <= 1'b0;
    end
  end

  // pending bits: an event wins over a clearing read in the same cycle, so none is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pend_reg <= 1'b0;
      rx0_pend_reg <= 1'b0;
      rx1_pend_reg <= 1'b0;
    end else begin
      if (tx_event) tx_pend_reg <= 1'b1;
      else if (rd_valid && rd_idx == FIS_IDX_TX_EVT) tx_pend_reg <= 1'b0;
      if (rx0_event) rx0_pend_reg <= 1'b1;
      else if (rd_rx_evt) rx0_pend_reg <= 1'b0;
      if (rx1_event) rx1_pend_reg <= 1'b1;
      else if (rd_rx_evt) rx1_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // block event status for this block's own interrupt (write one to clear)
  // ----------------------------------------------------------------------------
  logic [FIS_EV_W-1:0] ev_stat_reg;
  logic [FIS_EV_W-1:0] ev_set;
  logic [FIS_EV_W-1:0] ev_clr;
  logic aligned_d_reg;

  // delayed copy of the synchronized bit, used to see it rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) aligned_d_reg <= 1'b0;
    else aligned_d_reg <= aligned;
  end

  assign ev_set = {aligned && !aligned_d_reg, fail_pulse};
  assign ev_clr = (wr_pend_reg && wr_idx_reg == FIS_IDX_EVT_STAT) ? hwdata[FIS_EV_W-1:0] : '0;

  // write one to clear; an event in the clearing cycle stays set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev_stat_reg <= '0;
    else ev_stat_reg <= ev_set | (ev_stat_reg & ~ev_clr);
  end

  // ----------------------------------------------------------------------------
  // summary and outputs
  // ----------------------------------------------------------------------------
  logic summary;
  logic [7:0] irq_sts;

  assign summary = (tx_pend_reg && irq_ctl_reg[FIS_TX_BIT])
                || (rx1_pend_reg && irq_ctl_reg[FIS_RX1_BIT])
                || (rx0_pend_reg && irq_ctl_reg[FIS_RX0_BIT]);

  always_comb begin
    irq_sts = 8'h00;
    irq_sts[FIS_SUM_BIT] = summary;
    irq_sts[FIS_TX_BIT] = tx_pend_reg;
    irq_sts[FIS_RX1_BIT] = rx1_pend_reg;
    irq_sts[FIS_RX0_BIT] = rx0_pend_reg;
  end

  // outputs registered; interrupt follows status one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_n <= 1'b1;
      blk_irq <= 1'b0;
      fwd_grant <= 2'h0;
    end else begin
      irq_n <= !(summary && irq_ctl_reg[FIS_GIE_BIT]);
      blk_irq <= |(ev_stat_reg & ev_mask_reg);
      fwd_grant <= grant;
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (rd_idx)
      FIS_IDX_FWD_CTL: begin
        rdata_next[FIS_RR_BIT] = rr_en_reg;
        rdata_next[FIS_MODE_LO+1:FIS_MODE_LO] = mode_reg;
      end
      FIS_IDX_FORWARDING_SYNC_STATUS: begin
        rdata_next[FIS_FAIL_BIT] = fail_reg;
        rdata_next[FIS_SYNC_BIT] = aligned;
      end
      FIS_IDX_IRQ_CTL: rdata_next[7:0] = irq_ctl_reg;
      FIS_IDX_IRQ_STS: rdata_next[7:0] = irq_sts;
      FIS_IDX_EVT_MASK: rdata_next[FIS_EV_W-1:0] = ev_mask_reg;
      FIS_IDX_EVT_STAT: rdata_next[FIS_EV_W-1:0] = ev_stat_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read data captured at the address edge, so a clear-on-read still returns the old flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_reg <= 32'h0000_0000;
    else if (rd_valid) hrdata_reg <= rdata_next;
  end

  // no wait states: every register answers in the first data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1; // zero wait states, always okay
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------

  a_fail_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_forwarding_sync_status && !fail_pulse |=> !fail_reg)
    else $error("failure flag survived a status read");
  a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    !irq_ctl_reg[FIS_GIE_BIT] |=> irq_n)
    else $error("interrupt asserted with global enable off");
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    summary && irq_ctl_reg[FIS_GIE_BIT] |=> !irq_n)
    else $error("interrupt missing with enabled pending source");
  a_summary_tx: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_pend_reg && irq_ctl_reg[FIS_TX_BIT] |-> irq_sts[FIS_SUM_BIT])
    else $error("summary bit missing for enabled transmitter");
  a_tx_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_valid && rd_idx == FIS_IDX_TX_EVT && !tx_event |=> !tx_pend_reg)
    else $error("transmitter pending not cleared by event read");
  a_rx_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    rx0_pend_reg && !rd_rx_evt |=> rx0_pend_reg)
    else $error("receiver pending cleared without event read");
  a_rr_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> rr_en_reg)
    else $error("round-robin enable not set after reset");
  a_ctl_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_ctl_reg & ~FIS_IRQ_CTL_MASK) == 8'h00)
    else $error("reserved interrupt control bits set");
  a_fail_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    fail_pulse |=> fail_reg)
    else $error("failure flag not set by a failure pulse");
  a_sts_read_value: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_forwarding_sync_status |=> hrdata[FIS_FAIL_BIT] == $past(fail_reg))
    else $error("status read lost the failure flag");
  a_sync_read_value: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_forwarding_sync_status |=> hrdata[FIS_SYNC_BIT] == $past(aligned))
    else $error("status read does not show the synchronized bit");
  a_summary_rx: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx1_pend_reg && irq_ctl_reg[FIS_RX1_BIT]) || (rx0_pend_reg && irq_ctl_reg[FIS_RX0_BIT])
    |-> irq_sts[FIS_SUM_BIT])
    else $error("summary bit missing for enabled receiver");
  a_tx_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_event |=> tx_pend_reg)
    else $error("transmitter event did not set its pending bit");
  a_tx_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_pend_reg && !(rd_valid && rd_idx == FIS_IDX_TX_EVT) |=> tx_pend_reg)
    else $error("transmitter pending cleared without its event read");
  a_rx_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_rx_evt && !rx0_event && !rx1_event |=> !rx0_pend_reg && !rx1_pend_reg)
    else $error("receiver pending not cleared by event read");
  a_rx1_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    rx1_pend_reg && !rd_rx_evt |=> rx1_pend_reg)
    else $error("receiver one pending cleared without event read");
  a_rr_write_one: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && wr_idx_reg == FIS_IDX_FWD_CTL && hwdata[FIS_RR_BIT] |=> rr_en_reg)
    else $error("round-robin enable not set by a write of one");
  a_rr_write_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && wr_idx_reg == FIS_IDX_FWD_CTL && !hwdata[FIS_RR_BIT] |=> !rr_en_reg)
    else $error("round-robin enable not cleared by a write of zero");
  a_blk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    |(ev_stat_reg & ev_mask_reg) |=> blk_irq)
    else $error("block interrupt missing with unmasked event status");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule : fis_top
`default_nettype wire

// ===== dv/fis_host_model.sv
// host controller model that takes the active-low interrupt line
`timescale 1ns/1ns
`default_nettype none
module fis_host_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // interrupt line from the block
  input wire logic irq_n,
  // service routine entries taken so far
  output logic [7:0] irq_taken
);
  logic irq_n_reg;
  // count falling edges only: a long assertion is one entry, not many
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_n_reg <= 1'h1;
      irq_taken <= 8'h00;
    end else begin
      irq_n_reg <= irq_n;
      if (irq_n_reg && !irq_n) irq_taken <= irq_taken + 8'h01;
    end
  end
endmodule : fis_host_model
`default_nettype wire

// ===== dv/fis_top_tb.sv
// self-checking bench for the forwarding status and interrupt block
`timescale 1ns/1ns
`default_nettype none
module fis_top_tb
  import fis_pkg::*;
;
  // ----------------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_n, blk_irq;
  logic tx_event, rx0_event, rx1_event, frame_done, align_lost;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, src_ready, src_enabled, fwd_grant;
  logic [2:0] hsize;
  logic [7:0] irq_taken;
  int n_fail, num_checks;

  // the slave's hreadyout is the bus's hready
  fis_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_event(tx_event), .rx0_event(rx0_event),
    .rx1_event(rx1_event), .src_ready(src_ready), .src_enabled(src_enabled),
    .frame_done(frame_done), .align_lost(align_lost), .fwd_grant(fwd_grant), .irq_n(irq_n),
    .blk_irq(blk_irq));
  fis_host_model host (.hclk(hclk), .hresetn(hresetn), .irq_n(irq_n), .irq_taken(irq_taken));

  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // the master assumes no wait count; a stuck bus ends the run
  task wait_ready;
    for (int i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'h1) return;
    end
    n_fail++;
    results;
  endtask : wait_ready

  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= FIS_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'h1, idx, wd);
  endtask : wr

  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdchk

  // one-cycle pulses: bits are tx, rx0, rx1, frame done, alignment lost
  task pulse(input logic [4:0] m);
    @(posedge hclk);
    {align_lost, frame_done, rx1_event, rx0_event, tx_event} <= m;
    @(posedge hclk);
    {align_lost, frame_done, rx1_event, rx0_event, tx_event} <= 5'h00;
  endtask : pulse

  task wait_irq(input logic v);
    for (int i = 0; i < 8 && irq_n !== v; i++) @(posedge hclk);
    chk({31'h0, irq_n}, {31'h0, v});
    if (irq_n !== v) results;
  endtask : wait_irq

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task t_regs;
    rdchk(FIS_IDX_FWD_CTL, 32'h01);
    rdchk(FIS_IDX_IRQ_CTL, 32'h00);
    rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h00);
    rdchk(FIS_IDX_IRQ_STS, 32'h00);
    wr(FIS_IDX_IRQ_CTL, 32'hff);
    rdchk(FIS_IDX_IRQ_CTL, 32'h93);
    wr(FIS_IDX_IRQ_STS, 32'hff);
    rdchk(FIS_IDX_IRQ_STS, 32'h00);
    rdchk(8'h10, 32'h00);
    wr(FIS_IDX_FWD_CTL, 32'h00);
    rdchk(FIS_IDX_FWD_CTL, 32'h00);
    wr(FIS_IDX_FWD_CTL, 32'h01);
    rdchk(FIS_IDX_FWD_CTL, 32'h01);
  endtask : t_regs

  task t_irq;
    wr(FIS_IDX_IRQ_CTL, 32'h13);
    pulse(5'h07);
    rdchk(FIS_IDX_IRQ_STS, 32'h93);
    chk({31'h0, irq_n}, 32'h1);
    wr(FIS_IDX_IRQ_CTL, 32'h93);
    wait_irq(1'h0);
    // the host model counts at the edge that shows the fall; look once it has settled
    @(negedge hclk);
    chk({24'h0, irq_taken}, 32'h1);
    rdchk(FIS_IDX_IRQ_STS, 32'h93);
    rdchk(FIS_IDX_TX_EVT, 32'h00);
    rdchk(FIS_IDX_IRQ_STS, 32'h83);
    rdchk(FIS_IDX_RX_EVT_B, 32'h00);
    rdchk(FIS_IDX_IRQ_STS, 32'h00);
    wait_irq(1'h1);
    wr(FIS_IDX_IRQ_CTL, 32'h81);
    pulse(5'h04);
    rdchk(FIS_IDX_IRQ_STS, 32'h02);
    chk({31'h0, irq_n}, 32'h1);
    rdchk(FIS_IDX_RX_PKT_EVT, 32'h00);
    rdchk(FIS_IDX_IRQ_STS, 32'h00);
    pulse(5'h02);
    wait_irq(1'h0);
    wr(FIS_IDX_IRQ_CTL, 32'h01);
    wait_irq(1'h1);
    rdchk(FIS_IDX_IRQ_STS, 32'h81);
    rdchk(FIS_IDX_RX_EVT_A, 32'h00);
    rdchk(FIS_IDX_IRQ_STS, 32'h00);
  endtask : t_irq

  task t_rr;
    logic [1:0] prev;
    @(posedge hclk);
    src_ready <= 2'h1;
    repeat (3) @(posedge hclk);
    chk({30'h0, fwd_grant}, 32'h1);
    src_ready <= 2'h3;
    repeat (3) @(posedge hclk);
    prev = fwd_grant;
    chk({31'h0, ^prev}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      chk({30'h0, fwd_grant}, {30'h0, ~prev});
      prev = fwd_grant;
    end
    rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h00);
  endtask : t_rr

  task t_sync;
    @(posedge hclk);
    src_enabled <= 2'h3;
    wr(FIS_IDX_EVT_MASK, 32'h01);
    wr(FIS_IDX_FWD_CTL, 32'h04);
    rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h01);
    chk({30'h0, fwd_grant}, 32'h3);
    pulse(5'h10);
    rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h01);
    chk({31'h0, blk_irq}, 32'h0);
    pulse(5'h08);
    pulse(5'h10);
    rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h05);
    chk({31'h0, blk_irq}, 32'h1);
    rdchk(FIS_IDX_EVT_STAT, 32'h03);
    wr(FIS_IDX_EVT_STAT, 32'h03);
    rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h01);
    chk({31'h0, blk_irq}, 32'h0);
    for (int m = 1; m < 4; m++) begin
      wr(FIS_IDX_FWD_CTL, 32'(m << 2));
      rdchk(FIS_IDX_FWD_CTL, 32'(m << 2));
      rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h01);
    end
    @(posedge hclk);
    src_ready <= 2'h1;
    rdchk(FIS_IDX_FORWARDING_SYNC_STATUS, 32'h00);
    wr(FIS_IDX_FWD_CTL, 32'h01);
  endtask : t_sync

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    n_fail = 0;
    num_checks = 0;
    hresetn = 1'h0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {align_lost, frame_done, rx1_event, rx0_event, tx_event} = 5'h00;
    src_ready = 2'h0;
    src_enabled = 2'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs;
    t_irq;
    t_rr;
    t_sync;
    results;
  end
endmodule : fis_top_tb
`default_nettype wire
